// ### core/cmef_pkg.sv
// package for the communication module error flag bank
// holds the register indices, bit positions, masks, codes and state type;
// it is shared by the register bank and by the bench
package cmef_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_SUMMARY = 8'h0b;
    localparam logic [7:0] IDX_HW = 8'h0c;
    localparam logic [7:0] IDX_LINK1 = 8'h0d;
    localparam logic [7:0] IDX_LINK2 = 8'h0e;
    localparam logic [7:0] IDX_EXC1 = 8'h0f;
    localparam logic [7:0] IDX_EXC2 = 8'h10;
    localparam logic [7:0] IDX_COMM1 = 8'h11;
    localparam logic [7:0] IDX_COMM2 = 8'h12;
    localparam logic [7:0] IDX_COMM_INT = 8'h13;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h14;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'h15;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'h16;

    // summary error codes
    localparam logic [15:0] SUM_HW = 16'h0001;
    localparam logic [15:0] SUM_LINK = 16'h0002;
    localparam logic [15:0] SUM_COMM = 16'h0004;
    localparam logic [15:0] SUM_PROTO = 16'h0008;

    // hardware fault bit positions
    localparam int HW_FLASH = 0;
    localparam int HW_PINS = 1;
    localparam int HW_SRAM = 2;
    localparam int HW_LOW_VOLTAGE = 3;

    // user defined link error bit positions
    localparam int LK_GROUP = 0;
    localparam int LK_COMMAND = 1;
    localparam int LK_EDIT = 2;
    localparam int LK_COMPARE = 3;
    localparam int LK_CHECKSUM = 4;
    localparam int LK_SHORT = 6;
    localparam int LK_EXCESS = 7;
    localparam int LK_DATA_CHECK = 8;
    localparam int LK_PROCEDURE = 9;
    localparam int LK_SEGMENT_LO = 10;
    localparam int LK_SEGMENT_HI = 11;
    localparam int LK_READ_LEN = 12;
    localparam int LK_WRITE_LEN = 13;

    // communication error bit positions
    localparam int CM_TX_FORMAT = 0;
    localparam int CM_PARITY = 1;
    localparam int CM_LATE = 2;
    localparam int CM_TIMEOUT = 3;
    localparam int CM_CHECKSUM = 4;
    localparam int CM_INT_TIMEOUT = 5;
    localparam int CM_INT_ERROR = 6;
    localparam int CM_TX_FULL = 8;
    localparam int CM_RX_FULL = 9;

    // writable-by-hardware masks; reserved bits stay zero
    localparam logic [15:0] HW_MASK = 16'h000f;
    localparam logic [15:0] LINK_MASK = 16'h3fdf;
    localparam logic [15:0] COMM_MASK = 16'h037f;

    // protocol exception codes
    localparam logic [2:0] EXC_FUNCTION = 3'h1;
    localparam logic [2:0] EXC_ADDRESS = 3'h2;
    localparam logic [2:0] EXC_VALUE = 3'h3;
    localparam logic [2:0] EXC_SLAVE = 3'h4;
    localparam logic [2:0] EXC_CONVERT = 3'h5;

    // reset values
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    localparam logic [7:0] IRQ_RESET = 8'h00;

    // interrupt status bit order: one bit per stored register
    localparam int IRQ_HW = 0;
    localparam int IRQ_LINK1 = 1;
    localparam int IRQ_LINK2 = 2;
    localparam int IRQ_EXC1 = 3;
    localparam int IRQ_EXC2 = 4;
    localparam int IRQ_COMM1 = 5;
    localparam int IRQ_COMM2 = 6;
    localparam int IRQ_COMM_INT = 7;

    typedef struct packed {
        logic [15:0] hw;
        logic [15:0] link1;
        logic [15:0] link2;
        logic [15:0] exc1;
        logic [15:0] exc2;
        logic [15:0] comm1;
        logic [15:0] comm2;
        logic [15:0] comm_int;
        logic [7:0] irq_status;
        logic [7:0] irq_enable;
        logic irq;
        logic waitrequest;
        logic [31:0] readdata;
    } cmef_state_t;

endpackage : cmef_pkg

// ### core/cmef_regs.sv
// error flag register bank of the serial communication module
// assumes fault event pulses come from engines on the same clock;
// software reads the bank over an Avalon-MM slave with waitrequest
//
// Notes on behaviour
// RULE1 - summary code ORs 0x1 hardware, 0x2 link, 0x4 serial comm, 0x8 protocol
// RULE2 - hardware faults: bit0 flash, bit1 pins, bit2 SRAM, bit3 low voltage
// RULE3 - link bits: 0 group absent, 1 command absent, 2 packet edit error
// RULE4 - link bits: 3 compare mismatch, 6 data short, 7 excess data
// RULE5 - link bits: 4 checksum, 8 data check, 9 procedure, 10/11 segment format
// RULE6 - link bits 12/13 read/write length overrange; 5, 14, 15 reserved
// RULE7 - protocol exception register holds code 1 to 5
// RULE8 - comm bits: 0 transmit format error, 1 parity error
// RULE9 - comm bits: 2 data too late, 3 timeout
// RULE10 - comm bits: 4 checksum, 5/6 internal link, 8/9 buffers full
// RULE11 - three comm registers share one layout: two ports and internal link
// RULE12 - separate link and exception registers per serial port, consecutive indices
// RULE13 - flags stay set until device clears; host writes to them ignored
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps

module cmef_regs (
    input wire logic clock,
    input wire logic sys_rst,
    // avalon-mm slave, byte addressed
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // fault events from the detecting engines, one-cycle pulses
    input wire logic [15:0] hw_fault_event,
    input wire logic [15:0] port1_link_event,
    input wire logic [15:0] port2_link_event,
    input wire logic port1_exc_valid,
    input wire logic [2:0] port1_exc_code,
    input wire logic port2_exc_valid,
    input wire logic [2:0] port2_exc_code,
    input wire logic [15:0] port1_comm_event,
    input wire logic [15:0] port2_comm_event,
    input wire logic [15:0] internal_link_event,
    // device side clear, one bit per stored register in interrupt bit order
    input wire logic [7:0] flag_clear,
    output logic irq
);

    cmef_pkg::cmef_state_t state_reg;
    cmef_pkg::cmef_state_t state_next;

    logic [15:0] summary;
    logic [15:0] hw_set;
    logic [15:0] link1_set;
    logic [15:0] link2_set;
    logic [15:0] comm1_set;
    logic [15:0] comm2_set;
    logic [15:0] comm_int_set;
    logic exc1_ok;
    logic exc2_ok;
    logic [7:0] irq_event;
    logic req;
    logic [7:0] word_idx;
    logic aligned;

    // accept an exception code only if it is one of the defined ones,
    // so a stray code from the engine cannot leave a meaningless value
    function automatic logic code_ok(input logic [2:0] code);
        code_ok = (code == cmef_pkg::EXC_FUNCTION) || (code == cmef_pkg::EXC_ADDRESS)
            || (code == cmef_pkg::EXC_VALUE) || (code == cmef_pkg::EXC_SLAVE)
            || (code == cmef_pkg::EXC_CONVERT);
    endfunction : code_ok

    // reserved positions are masked so they always read zero
    always_comb begin
        hw_set = hw_fault_event & cmef_pkg::HW_MASK; // [RULE2]
        link1_set = port1_link_event & cmef_pkg::LINK_MASK; // [RULE3] [RULE4] [RULE5] [RULE6]
        link2_set = port2_link_event & cmef_pkg::LINK_MASK; // [RULE12]
        comm1_set = port1_comm_event & cmef_pkg::COMM_MASK; // [RULE8] [RULE9] [RULE10]
        comm2_set = port2_comm_event & cmef_pkg::COMM_MASK; // [RULE11]
        comm_int_set = internal_link_event & cmef_pkg::COMM_MASK; // [RULE11]
        exc1_ok = port1_exc_valid && code_ok(port1_exc_code); // [RULE7]
        exc2_ok = port2_exc_valid && code_ok(port2_exc_code); // [RULE7] [RULE12]
    end

    // one interrupt event per stored register whenever a new fault lands
    always_comb begin
        irq_event = 8'h00;
        irq_event[cmef_pkg::IRQ_HW] = |hw_set;
        irq_event[cmef_pkg::IRQ_LINK1] = |link1_set;
        irq_event[cmef_pkg::IRQ_LINK2] = |link2_set;
        irq_event[cmef_pkg::IRQ_EXC1] = exc1_ok;
        irq_event[cmef_pkg::IRQ_EXC2] = exc2_ok;
        irq_event[cmef_pkg::IRQ_COMM1] = |comm1_set;
        irq_event[cmef_pkg::IRQ_COMM2] = |comm2_set;
        irq_event[cmef_pkg::IRQ_COMM_INT] = |comm_int_set;
    end

    // summary code is derived live from the stored flags; several
    // categories at once simply OR their codes together
    always_comb begin
        summary = 16'h0000;
        if (|state_reg.hw) begin
            summary = summary | cmef_pkg::SUM_HW; // [RULE1]
        end
        if (|(state_reg.link1 | state_reg.link2)) begin
            summary = summary | cmef_pkg::SUM_LINK; // [RULE1]
        end
        if (|(state_reg.comm1 | state_reg.comm2 | state_reg.comm_int)) begin
            summary = summary | cmef_pkg::SUM_COMM; // [RULE1]
        end
        if (|(state_reg.exc1 | state_reg.exc2)) begin
            summary = summary | cmef_pkg::SUM_PROTO; // [RULE1]
        end
    end

    // bus decode helpers
    assign req = avs_read || avs_write;
    assign word_idx = {2'b00, avs_address[7:2]};
    assign aligned = (avs_address[1:0] == 2'b00);

    // next state: sticky flags, interrupt bank and bus slave
    always_comb begin
        state_next = state_reg;

        // flags: set wins over a device clear in the same cycle
        state_next.hw = (flag_clear[cmef_pkg::IRQ_HW] ? 16'h0000 : state_reg.hw) | hw_set; // [RULE13]
        state_next.link1 = (flag_clear[cmef_pkg::IRQ_LINK1] ? 16'h0000 : state_reg.link1) | link1_set; // [RULE13]
        state_next.link2 = (flag_clear[cmef_pkg::IRQ_LINK2] ? 16'h0000 : state_reg.link2) | link2_set; // [RULE13]
        state_next.comm1 = (flag_clear[cmef_pkg::IRQ_COMM1] ? 16'h0000 : state_reg.comm1) | comm1_set; // [RULE13]
        state_next.comm2 = (flag_clear[cmef_pkg::IRQ_COMM2] ? 16'h0000 : state_reg.comm2) | comm2_set; // [RULE13]
        state_next.comm_int = (flag_clear[cmef_pkg::IRQ_COMM_INT] ? 16'h0000 : state_reg.comm_int)
            | comm_int_set; // [RULE13]

        // exception codes: a new code replaces the old one, clear otherwise
        if (exc1_ok) begin
            state_next.exc1 = {13'h0000, port1_exc_code}; // [RULE7]
        end else if (flag_clear[cmef_pkg::IRQ_EXC1]) begin
            state_next.exc1 = 16'h0000; // [RULE13]
        end
        if (exc2_ok) begin
            state_next.exc2 = {13'h0000, port2_exc_code}; // [RULE7]
        end else if (flag_clear[cmef_pkg::IRQ_EXC2]) begin
            state_next.exc2 = 16'h0000; // [RULE13]
        end

        // waitrequest drops for one cycle, one cycle after a request shows;
        // a request is completed at the edge where waitrequest is low
        state_next.waitrequest = !(req && state_reg.waitrequest);

        // interrupt status: software clear takes effect at completion, set wins
        if (avs_write && !state_reg.waitrequest && aligned) begin
            if (word_idx == cmef_pkg::IDX_IRQ_CLEAR) begin
                state_next.irq_status = state_reg.irq_status & ~avs_writedata[7:0];
            end else if (word_idx == cmef_pkg::IDX_IRQ_ENABLE) begin
                state_next.irq_enable = avs_writedata[7:0];
            end
            // writes to the flag registers and unmapped words are dropped
        end
        state_next.irq_status = state_next.irq_status | irq_event;

        // registered interrupt level follows the next status and enable
        state_next.irq = |(state_next.irq_status & state_next.irq_enable);

        // read data captured in the waiting cycle, shown while wait is low;
        // unmapped or misaligned reads return zero
        if (avs_read && state_reg.waitrequest) begin
            state_next.readdata = 32'h0000_0000;
            if (!aligned) begin
                state_next.readdata = 32'h0000_0000;
            end else if (word_idx == cmef_pkg::IDX_SUMMARY) begin
                state_next.readdata = {16'h0000, summary};
            end else if (word_idx == cmef_pkg::IDX_HW) begin
                state_next.readdata = {16'h0000, state_reg.hw};
            end else if (word_idx == cmef_pkg::IDX_LINK1) begin
                state_next.readdata = {16'h0000, state_reg.link1};
            end else if (word_idx == cmef_pkg::IDX_LINK2) begin
                state_next.readdata = {16'h0000, state_reg.link2}; // [RULE12]
            end else if (word_idx == cmef_pkg::IDX_EXC1) begin
                state_next.readdata = {16'h0000, state_reg.exc1};
            end else if (word_idx == cmef_pkg::IDX_EXC2) begin
                state_next.readdata = {16'h0000, state_reg.exc2}; // [RULE12]
            end else if (word_idx == cmef_pkg::IDX_COMM1) begin
                state_next.readdata = {16'h0000, state_reg.comm1}; // [RULE11]
            end else if (word_idx == cmef_pkg::IDX_COMM2) begin
                state_next.readdata = {16'h0000, state_reg.comm2}; // [RULE11]
            end else if (word_idx == cmef_pkg::IDX_COMM_INT) begin
                state_next.readdata = {16'h0000, state_reg.comm_int}; // [RULE11]
            end else if (word_idx == cmef_pkg::IDX_IRQ_STATUS) begin
                state_next.readdata = {24'h000000, state_reg.irq_status};
            end else if (word_idx == cmef_pkg::IDX_IRQ_ENABLE) begin
                state_next.readdata = {24'h000000, state_reg.irq_enable};
            end
        end
    end

    // single state register; reset holds the bus in wait and clears flags
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg.hw <= cmef_pkg::FLAG_RESET;
            state_reg.link1 <= cmef_pkg::FLAG_RESET;
            state_reg.link2 <= cmef_pkg::FLAG_RESET;
            state_reg.exc1 <= cmef_pkg::FLAG_RESET;
            state_reg.exc2 <= cmef_pkg::FLAG_RESET;
            state_reg.comm1 <= cmef_pkg::FLAG_RESET;
            state_reg.comm2 <= cmef_pkg::FLAG_RESET;
            state_reg.comm_int <= cmef_pkg::FLAG_RESET;
            state_reg.irq_status <= cmef_pkg::IRQ_RESET;
            state_reg.irq_enable <= cmef_pkg::IRQ_RESET;
            state_reg.irq <= 1'b0;
            state_reg.waitrequest <= 1'b1;
            state_reg.readdata <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops
    assign avs_readdata = state_reg.readdata;
    assign avs_waitrequest = state_reg.waitrequest;
    assign irq = state_reg.irq;

endmodule : cmef_regs

// ### tb/cmef_host.sv
// host controller model: avalon-mm master doing single reads and writes
// assumes one clock shared with the bank; the bench calls its task
`timescale 1ns/1ps
module cmef_host (
    input wire logic clock,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata
);
    initial begin
        avs_address = 8'hff;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
    end
    // released address and write data get the inverse, read and write drop low, so a stale address never looks valid
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output bit to);
        int n;
        to = 1'b1;
        rd = 32'h0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) begin
                rd = avs_readdata;
                to = 1'b0;
                break;
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~wd;
    endtask : xfer
endmodule : cmef_host

// ### tb/cmef_props.sv
// checker for the error flag bank: bus answer timing and read data ranges
// assumes it is bound to cmef_regs and sees its ports only
`timescale 1ns/1ps
module cmef_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // a read answered at byte address a
    sequence rd_at(a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    // a request seen for the first time
    sequence req_new;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    answer_next_a: assert property (req_new |=> !avs_waitrequest)
        else $error("request not answered in the next cycle");
    wait_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    idle_wait_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("answer without request");
    summary_code_a: assert property (rd_at(8'h2c) |-> avs_readdata[31:4] == 28'h0)
        else $error("summary code outside its four codes");
    hw_reserved_a: assert property (rd_at(8'h30) |-> avs_readdata[31:4] == 28'h0)
        else $error("hardware reserved bits set");
    link_reserved_a: assert property ((rd_at(8'h34) or rd_at(8'h38)) |->
        (avs_readdata & ~{16'h0, cmef_pkg::LINK_MASK}) == 32'h0) else $error("link reserved bits set");
    comm_reserved_a: assert property ((rd_at(8'h44) or rd_at(8'h48) or rd_at(8'h4c)) |->
        (avs_readdata & ~{16'h0, cmef_pkg::COMM_MASK}) == 32'h0) else $error("comm reserved bits set");
    exc_range_a: assert property ((rd_at(8'h3c) or rd_at(8'h40)) |-> avs_readdata <= 32'h5)
        else $error("exception code out of range");
endmodule : cmef_props

bind cmef_regs cmef_props cmef_props_inst (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// ### tb/testbench.sv
// bench for the error flag bank: event pulses, host reads, irq
// assumes the host model for bus traffic; expectations come from bench functions
`timescale 1ns/1ps
module testbench;
    logic clock;
    logic sys_rst;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic [15:0] ev [8];
    logic [7:0] flag_clear;
    logic [15:0] exp_reg [8];
    logic [7:0] exp_stat;
    logic [7:0] enable;
    logic [31:0] d;
    int num_errors;
    int comparisons;
    int seed;
    int i;
    int r;
    bit to;
    cmef_regs cmef_regs_inst (.clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hw_fault_event(ev[0]), .port1_link_event(ev[1]),
        .port2_link_event(ev[2]), .port1_exc_valid(ev[3][15]), .port1_exc_code(ev[3][2:0]),
        .port2_exc_valid(ev[4][15]), .port2_exc_code(ev[4][2:0]), .port1_comm_event(ev[5]),
        .port2_comm_event(ev[6]), .internal_link_event(ev[7]), .flag_clear(flag_clear), .irq(irq));
    cmef_host cmef_host_inst (.clock(clock), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    function automatic logic [15:0] mask(int k);
        return k == 0 ? cmef_pkg::HW_MASK : k < 3 ? cmef_pkg::LINK_MASK : cmef_pkg::COMM_MASK;
    endfunction : mask
    // internal link faults count as communication faults too
    function automatic logic [15:0] summary();
        logic [15:0] s;
        s = 16'h0;
        if (exp_reg[0] != 0) s = s | cmef_pkg::SUM_HW;
        if ((exp_reg[1] | exp_reg[2]) != 0) s = s | cmef_pkg::SUM_LINK;
        if ((exp_reg[5] | exp_reg[6] | exp_reg[7]) != 0) s = s | cmef_pkg::SUM_COMM;
        if ((exp_reg[3] | exp_reg[4]) != 0) s = s | cmef_pkg::SUM_PROTO;
        return s;
    endfunction : summary
    task final_report();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task chk(string n, logic [31:0] e, logic [31:0] s);
        comparisons++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            num_errors++;
        end
    endtask : chk
    task bus(logic w, logic [7:0] a, logic [31:0] wd);
        cmef_host_inst.xfer(w, a, wd, d, to);
        if (to) begin
            num_errors++;
            final_report();
        end
    endtask : bus
    // one event cycle; a same-cycle event beats a clear
    task pulse(int k, logic [15:0] v, logic [7:0] clr);
        @(posedge clock);
        ev[k] <= v;
        flag_clear <= clr;
        @(posedge clock);
        ev[k] <= 16'h0;
        flag_clear <= 8'h0;
        for (int j = 0; j < 8; j++) if (clr[j]) exp_reg[j] = 16'h0;
        if (k == 3 || k == 4) begin
            if (v[15] && v[2:0] >= 3'h1 && v[2:0] <= 3'h5) begin
                exp_reg[k] = {13'h0, v[2:0]};
                exp_stat[k] = 1'b1;
            end
        end else if ((v & mask(k)) != 0) begin
            exp_reg[k] = exp_reg[k] | (v & mask(k));
            exp_stat[k] = 1'b1;
        end
    endtask : pulse
    task check_all();
        bus(0, 8'h2c, 0);
        chk("summary", {16'h0, summary()}, d);
        for (int k = 0; k < 8; k++) begin
            bus(0, 8'h30 + 8'(4 * k), 0);
            chk("flags", {16'h0, exp_reg[k]}, d);
        end
        bus(0, 8'h50, 0);
        chk("irq_status", {24'h0, exp_stat}, d);
        bus(0, 8'h54, 0);
        chk("irq_enable", {24'h0, enable}, d);
        chk("irq", {31'h0, |(exp_stat & enable)}, {31'h0, irq});
    endtask : check_all
    initial begin
        sys_rst = 1'b1;
        flag_clear = 8'h0;
        for (i = 0; i < 8; i++) ev[i] = 16'h0;
        for (i = 0; i < 8; i++) exp_reg[i] = 16'h0;
        exp_stat = 8'h0;
        enable = 8'h0;
        seed = 32'h08c3;
        num_errors = 0;
        comparisons = 0;
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        check_all();
        enable = 8'($random(seed));
        bus(1, 8'h54, {24'h0, enable});
        // every bit of every register once, then every exception code
        for (r = 0; r < 8; r++) begin
            for (i = 0; i < 16; i++) pulse(r, 16'h1 << i, 8'h0);
            check_all();
        end
        for (i = 0; i < 8; i++) begin
            pulse(3 + i % 2, 16'h8000 | 16'(i), 8'h0);
            check_all();
        end
        // host writes to the flags must not change them
        for (r = 0; r < 9; r++) bus(1, 8'h2c + 8'(4 * r), $random(seed));
        bus(0, 8'h60, 0);
        chk("unmapped", 32'h0, d);
        bus(0, 8'h31, 0);
        chk("misaligned", 32'h0, d);
        check_all();
        for (i = 0; i < 40; i++) begin
            r = {$random(seed)} % 8;
            pulse(r, 16'($random(seed)), (i % 5 == 0) ? 8'($random(seed)) : 8'h0);
            if (i % 7 == 0) begin
                d = 32'($random(seed)) & 32'hff;
                // the bus task hands back read data in d, so take the expectation first
                exp_stat = exp_stat & ~d[7:0];
                bus(1, 8'h58, d);
                enable = 8'($random(seed));
                bus(1, 8'h54, {24'h0, enable});
            end
            check_all();
        end
        final_report();
    end
endmodule : testbench
